//--- test/infrared_stack_host_uart_port_tb_top.sv
// Testbench: host end and port device joined, infrared side driven here
`timescale 1ns/1ps
module infrared_stack_host_uart_port_tb_top;
   import ispu_pkg::*;
   localparam int unsigned DIV   = 8;
   localparam int unsigned DEPTH = 8;
   localparam int unsigned IDLE  = 2000;
   logic       clk_sys;
   logic       rst;
   ispu_byte_t tx_data;
   ispu_byte_t rx_data;
   logic       tx_valid, tx_ready, rx_valid, rx_ready, ir_wanted, ring_req;
   logic       carrier_req, dev_reset_req, dev_enable_req, link_seen;
   logic       ir_serial_out, ir_serial_in, link_active, ok;
   logic [8:0] w;
   int         fails = 0;
   int         n_checks = 0;
   int         cycles = 0;
   int         sent;
   ispu_byte_t rxq[$];

   ispu_host_if ispu_host_if_i ();
   wire link_n   = ispu_host_if_i.link_up_n;
   wire permit_n = ispu_host_if_i.send_permit_n;

   ispu_dev #(.DIV(DIV), .DEPTH(DEPTH), .LINK_IDLE(IDLE)) ispu_dev_i (
      .clk_sys(clk_sys), .rst(rst), .hp(ispu_host_if_i.device),
      .ir_serial_out(ir_serial_out), .ir_serial_in(ir_serial_in),
      .link_active(link_active));
   ispu_host #(.DIV(DIV)) ispu_host_i (
      .clk_sys(clk_sys), .rst(rst), .hp(ispu_host_if_i.host),
      .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .ir_wanted(ir_wanted), .ring_req(ring_req),
      .carrier_req(carrier_req), .dev_reset_req(dev_reset_req),
      .dev_enable_req(dev_enable_req), .link_seen(link_seen));
   ispu_port_sva #(.DIV(DIV)) ispu_port_sva_i (
      .clk_sys(clk_sys), .rst(rst),
      .host_serial_in(ispu_host_if_i.host_serial_in),
      .host_serial_out(ispu_host_if_i.host_serial_out),
      .link_up_n(link_n), .send_permit_n(permit_n),
      .host_accept_n(ispu_host_if_i.host_accept_n),
      .dev_reset(ispu_host_if_i.dev_reset),
      .dev_enable(ispu_host_if_i.dev_enable),
      .ir_serial_out(ir_serial_out), .link_active(link_active));

   // Clock at 100 MHz
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Hang guard and collector, sampled between edges so outputs are settled
   always @(negedge clk_sys) begin
      cycles <= cycles + 1;
      if (rx_valid === 1'b1)
         rxq.push_back(rx_data);
      if (cycles == 20000) begin
         fails++;
         test_done();
      end
   end

   task automatic check(input string name, input logic [15:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk_sys);
   endtask

   // Remote station frame: start, nine bits LSB first, stop
   task automatic ir_send(input logic [8:0] v);
      logic [10:0] f;
      f = {1'b1, v, 1'b0};
      for (int i = 0; i < 11; i++) begin
         ir_serial_in = f[i];
         cyc(DIV);
      end
   endtask

   // Catch one frame from the device, sampling mid-bit
   task automatic ir_recv(output logic [8:0] v);
      int n;
      n = 0;
      while (ir_serial_out !== 1'b0 && n < 3000) begin
         cyc(1);
         n++;
      end
      cyc(DIV / 2);
      check("ir_start", ir_serial_out, 1'b0);
      for (int i = 0; i < 9; i++) begin
         cyc(DIV);
         v[i] = ir_serial_out;
      end
      cyc(DIV);
      check("ir_stop", ir_serial_out, 1'b1);
   endtask

   // Offer one byte; valid stays up so back-to-back offers need no gap
   task automatic host_send(input ispu_byte_t b, output logic acc);
      int n;
      n = 0;
      tx_data = b;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1 && n < 300) begin
         cyc(1);
         n++;
      end
      acc = (tx_ready === 1'b1);
      cyc(1);
   endtask

   task automatic wait_rx(input int k);
      int n;
      n = 0;
      while (rxq.size() < k && n < 400) begin
         cyc(1);
         n++;
      end
   endtask

   task automatic test_done();
      $display("Checks made %0d, mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Main sequence
   initial begin
      rst = 1'b1;
      tx_data = 8'h00;
      tx_valid = 1'b0;
      rx_ready = 1'b1;
      ir_wanted = 1'b1;
      ring_req = 1'b0;
      carrier_req = 1'b1;
      dev_reset_req = 1'b0;
      dev_enable_req = 1'b1;
      ir_serial_in = 1'b1;
      repeat (5) @(posedge clk_sys);
      @(negedge clk_sys);
      rst = 1'b0;
      cyc(4);
      check("link_up_n", link_n, 1'b1);
      check("permit", permit_n, 1'b0);
      // No link drains the FIFO: offers are refused once only one slot is left free
      sent = 0;
      for (int i = 0; i < 9; i++) begin
         host_send(8'h30 + 8'(i), ok);
         if (ok === 1'b1)
            sent++;
      end
      tx_valid = 1'b0;
      check("accepted", 16'(sent), 16'(DEPTH - 1));
      check("permit", permit_n, 1'b1);
      // Remote frame opens the link; status frame comes first
      fork
         ir_send(9'h1ff);
         ir_recv(w);
      join
      check("status", w, {1'b1, 5'h0, 1'b1, 1'b0, 1'b0});
      check("link_up_n", link_n, 1'b0);
      check("link_seen", link_seen, 1'b1);
      check("link_active", link_active, 1'b1);
      for (int i = 0; i < DEPTH - 1; i++) begin
         ir_recv(w);
         check("ir_data", w, {1'b0, 8'h30 + 8'(i)});
      end
      cyc(4);
      check("permit", permit_n, 1'b0);
      // Every status pin flips at once
      ring_req = 1'b1;
      ir_wanted = 1'b0;
      carrier_req = 1'b0;
      ir_recv(w);
      check("status", w, {1'b1, 5'h0, 1'b0, 1'b1, 1'b1});
      ir_send(9'h100);
      cyc(4);
      check("link_up_n", link_n, 1'b0);
      // Host refuses, then takes characters back to back
      rx_ready = 1'b0;
      cyc(2);
      ir_send({1'b0, 8'h5a});
      cyc(30 * DIV);
      check("held", 16'(rxq.size()), 16'h0);
      rx_ready = 1'b1;
      ir_send({1'b0, 8'ha5});
      ir_send({1'b0, 8'h01});
      wait_rx(3);
      check("rx0", rxq[0], 8'h5a);
      check("rx1", rxq[1], 8'ha5);
      check("rx2", rxq[2], 8'h01);
      // Link times out without remote traffic
      cyc(IDLE + 50);
      check("link_up_n", link_n, 1'b1);
      check("link_seen", link_seen, 1'b0);
      // Clear by reset pin, then by enable pin
      for (int j = 0; j < 2; j++) begin
         ir_send(9'h100);
         cyc(4);
         check("link_up_n", link_n, 1'b0);
         dev_reset_req = (j == 0);
         dev_enable_req = (j == 0);
         cyc(6);
         check("link_up_n", link_n, 1'b1);
         check("permit", permit_n, 1'b1);
         dev_reset_req = 1'b0;
         dev_enable_req = 1'b1;
         cyc(6);
         check("permit", permit_n, 1'b0);
      end
      test_done();
   end
endmodule

//--- test/ispu_port_sva.sv
// Checker on the host pins and the infrared output of the port device
`timescale 1ns/1ps
module ispu_port_sva #(
   parameter int unsigned DIV = 8
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic host_serial_in,
   input wire logic host_serial_out,
   input wire logic link_up_n,
   input wire logic send_permit_n,
   input wire logic host_accept_n,
   input wire logic dev_reset,
   input wire logic dev_enable,
   input wire logic ir_serial_out,
   input wire logic link_active
);
   localparam int unsigned FRAME = 10 * DIV;
   logic [15:0] in_cnt_q;
   logic [15:0] in_cnt_d;
   logic [15:0] out_cnt_q;
   logic [15:0] out_cnt_d;
   logic [15:0] quiet_q;
   logic [15:0] quiet_d;
   logic        in_start;
   logic        out_start;

   // A low line while no frame runs marks a start bit
   assign in_start  = (in_cnt_q == 16'h0) && !host_serial_in;
   assign out_start = (out_cnt_q == 16'h0) && !host_serial_out;

   // Frame trackers count down one frame; quiet counts link-down cycles
   always_comb begin
      in_cnt_d  = in_start ? 16'(FRAME - 1) :
                  in_cnt_q - 16'(in_cnt_q != 16'h0);
      out_cnt_d = out_start ? 16'(FRAME - 1) :
                  out_cnt_q - 16'(out_cnt_q != 16'h0);
      quiet_d   = link_up_n ? quiet_q + 16'(quiet_q != 16'hffff) : 16'h0;
   end

   // Registers of the trackers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         in_cnt_q  <= 16'h0;
         out_cnt_q <= 16'h0;
         quiet_q   <= 16'h0;
      end else begin
         in_cnt_q  <= in_cnt_d;
         out_cnt_q <= out_cnt_d;
         quiet_q   <= quiet_d;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   in_start_a: assert property (
      in_cnt_q > 16'(FRAME - DIV) |-> !host_serial_in)
      else $error("host to device start bit not held low");
   in_stop_a: assert property (
      in_cnt_q != 16'h0 && in_cnt_q <= 16'(DIV) |-> host_serial_in)
      else $error("host to device stop bit not high");
   out_start_a: assert property (
      out_cnt_q > 16'(FRAME - DIV) |-> !host_serial_out)
      else $error("device to host start bit not held low");
   out_stop_a: assert property (
      out_cnt_q != 16'h0 && out_cnt_q <= 16'(DIV) |-> host_serial_out)
      else $error("device to host stop bit not high");
   permit_hold_a: assert property (
      in_start |-> !$past(send_permit_n) || !$past(send_permit_n, 2))
      else $error("host started a character while held off");
   accept_hold_a: assert property (
      out_start |-> !($past(host_accept_n) && $past(host_accept_n, 2)
                      && $past(host_accept_n, 3)))
      else $error("device started a character while host refused");
   clear_state_a: assert property (
      (dev_reset || !dev_enable) [*3] |-> send_permit_n && link_up_n)
      else $error("cleared device still permits or shows link");
   permit_back_a: assert property (
      $fell(dev_reset) && dev_enable |-> ##[1:3] !send_permit_n)
      else $error("permit not given after device clear");
   enable_back_a: assert property (
      $rose(dev_enable) && !dev_reset |-> ##[1:3] !send_permit_n)
      else $error("permit not given after device enable");
   ir_quiet_a: assert property (
      quiet_q > 16'(11 * DIV) |-> ir_serial_out)
      else $error("infrared output active without a link");
   link_flag_a: assert property (
      link_active == !link_up_n)
      else $error("link flag disagrees with link pin");
endmodule

//--- verilog/ispu_dev.sv
// Device end: serial engines, FIFO and the port device top
`timescale 1ns/1ps
`include "ispu_params.svh"

// Serial transmitter: start bit, W bits LSB first, stop bit
module ispu_ser_tx #(
   parameter int unsigned W   = `ISPU_DATA_W,
   parameter int unsigned DIV = `ISPU_BAUD_DIV
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         clr,
   input  wire logic [W-1:0] in_data,
   input  wire logic         in_valid,
   output logic              in_ready,
   output logic              ser_out
);
   import ispu_pkg::*;
   ispu_ser_e      st_q, st_d;
   logic [15:0]    div_q, div_d;
   logic [3:0]     cnt_q, cnt_d;
   logic [W:0]     sh_q, sh_d;
   logic           out_q, out_d;

   assign in_ready = (st_q == SER_IDLE) && !clr;
   assign ser_out  = out_q;

   // Frame sequencing, one bit every DIV cycles
   always_comb begin
      st_d  = st_q;
      div_d = div_q;
      cnt_d = cnt_q;
      sh_d  = sh_q;
      out_d = out_q;
      case (st_q)
         SER_IDLE: begin
            out_d = `ISPU_LINE_IDLE;
            if (in_valid && !clr) begin
               sh_d  = {`ISPU_LINE_IDLE, in_data};
               out_d = 1'b0;
               div_d = 16'h0;
               cnt_d = 4'h0;
               st_d  = SER_DATA;
            end
         end
         SER_DATA: begin
            div_d = div_q + 16'h1;
            if (div_q == 16'(DIV - 1)) begin
               div_d = 16'h0;
               out_d = sh_q[0];
               sh_d  = {`ISPU_LINE_IDLE, sh_q[W:1]};
               cnt_d = cnt_q + 4'h1;
               if (cnt_q == 4'(W + 1)) begin
                  out_d = `ISPU_LINE_IDLE;
                  st_d  = SER_IDLE;
               end
            end
         end
         default: st_d = SER_IDLE;
      endcase
      if (clr) begin
         st_d  = SER_IDLE;
         out_d = `ISPU_LINE_IDLE;
      end
   end

   // State registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q  <= SER_IDLE;
         div_q <= 16'h0;
         cnt_q <= 4'h0;
         sh_q  <= '1;
         out_q <= `ISPU_LINE_IDLE;
      end else begin
         st_q  <= st_d;
         div_q <= div_d;
         cnt_q <= cnt_d;
         sh_q  <= sh_d;
         out_q <= out_d;
      end
   end
endmodule

// Serial receiver: mid-bit sampling, stop bit checked
module ispu_ser_rx #(
   parameter int unsigned W   = `ISPU_DATA_W,
   parameter int unsigned DIV = `ISPU_BAUD_DIV
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   input  wire logic         clr,
   input  wire logic         ser_in,
   output logic [W-1:0]      out_data,
   output logic              out_valid
);
   import ispu_pkg::*;
   ispu_ser_e      st_q, st_d;
   logic [15:0]    div_q, div_d;
   logic [3:0]     cnt_q, cnt_d;
   logic [W-1:0]   sh_q, sh_d, dat_q, dat_d;
   logic           vld_q, vld_d;

   assign out_data  = dat_q;
   assign out_valid = vld_q;

   // Start detect, data shift, stop check
   always_comb begin
      st_d  = st_q;
      div_d = div_q + 16'h1;
      cnt_d = cnt_q;
      sh_d  = sh_q;
      dat_d = dat_q;
      vld_d = 1'b0;
      case (st_q)
         SER_IDLE: begin
            div_d = 16'h0;
            if (!ser_in) st_d = SER_START;
         end
         SER_START: begin
            if (div_q == 16'(DIV / 2 - 1)) begin
               div_d = 16'h0;
               cnt_d = 4'h0;
               st_d  = ser_in ? SER_IDLE : SER_DATA;
            end
         end
         SER_DATA: begin
            if (div_q == 16'(DIV - 1)) begin
               div_d = 16'h0;
               sh_d  = {ser_in, sh_q[W-1:1]};
               cnt_d = cnt_q + 4'h1;
               if (cnt_q == 4'(W - 1)) st_d = SER_STOP;
            end
         end
         SER_STOP: begin
            if (div_q == 16'(DIV - 1)) begin
               st_d  = SER_IDLE;
               vld_d = ser_in;      // Bad stop bit drops the character
               if (ser_in) dat_d = sh_q;
            end
         end
         default: st_d = SER_IDLE;
      endcase
      if (clr) begin
         st_d  = SER_IDLE;
         vld_d = 1'b0;
      end
   end

   // State registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_q  <= SER_IDLE;
         div_q <= 16'h0;
         cnt_q <= 4'h0;
         sh_q  <= '0;
         dat_q <= '0;
         vld_q <= 1'b0;
      end else begin
         st_q  <= st_d;
         div_q <= div_d;
         cnt_q <= cnt_d;
         sh_q  <= sh_d;
         dat_q <= dat_d;
         vld_q <= vld_d;
      end
   end
endmodule

// Synchronous FIFO, DEPTH a power of two
module ispu_fifo #(
   parameter int unsigned W     = `ISPU_DATA_W,
   parameter int unsigned DEPTH = `ISPU_FIFO_DEPTH
) (
   input  wire logic                   clk_sys,
   input  wire logic                   rst,
   input  wire logic                   clr,
   input  wire logic [W-1:0]           in_data,
   input  wire logic                   in_valid,
   output logic                        in_ready,
   output logic [W-1:0]                out_data,
   output logic                        out_valid,
   input  wire logic                   out_ready,
   output logic [$clog2(DEPTH):0]      level
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [W-1:0]  mem_q [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0]   cnt_q, cnt_d;
   logic          push, pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rd_q];
   assign level     = cnt_q;
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   // Pointer and count update
   always_comb begin
      wr_d  = wr_q + AW'(push);
      rd_d  = rd_q + AW'(pop);
      cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      if (clr) begin
         wr_d  = '0;
         rd_d  = '0;
         cnt_d = '0;
      end
   end

   // Pointer registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         wr_q  <= wr_d;
         rd_q  <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // Storage, written only on a push
   always_ff @(posedge clk_sys) begin
      if (push) mem_q[wr_q] <= in_data;
   end
endmodule

// Port device: host serial side and infrared side
module ispu_dev #(
   parameter int unsigned DIV       = `ISPU_BAUD_DIV,
   parameter int unsigned DEPTH     = `ISPU_FIFO_DEPTH,
   parameter int unsigned LINK_IDLE = `ISPU_LINK_IDLE_CYC
) (
   input  wire logic  clk_sys,
   input  wire logic  rst,
   ispu_host_if.device hp,
   output logic       ir_serial_out,
   input  wire logic  ir_serial_in,
   output logic       link_active
);
   import ispu_pkg::*;
   localparam int unsigned LW = $clog2(DEPTH) + 1;

   logic                  clr;
   ispu_byte_t            hrx_data, up_data, dn_data;
   logic                  hrx_vld, up_vld, up_rdy, dn_vld, dn_rdy;
   logic                  dn_in_rdy, htx_rdy, irtx_vld, irtx_rdy;
   logic [`ISPU_IR_W-1:0] irrx_data, irtx_data;
   logic                  irrx_vld, ctrl_pend;
   logic [LW-1:0]         up_lvl;
   logic [2:0]            stat_q, stat_d, sent_q, sent_d;
   logic                  ok_q, ok_d, link_q, link_d, permit_n_q, permit_n_d;
   logic [31:0]           idle_q, idle_d;

   // Host reset pin or a low enable holds the port idle
   assign clr = hp.dev_reset || !hp.dev_enable;

   // Host characters in, buffered toward the infrared side
   ispu_ser_rx #(.W(`ISPU_DATA_W), .DIV(DIV)) u_hrx (
      .clk_sys(clk_sys), .rst(rst), .clr(clr),
      .ser_in(hp.host_serial_in),
      .out_data(hrx_data), .out_valid(hrx_vld));

   ispu_fifo #(.W(`ISPU_DATA_W), .DEPTH(DEPTH)) u_up (
      .clk_sys(clk_sys), .rst(rst), .clr(clr),
      .in_data(hrx_data), .in_valid(hrx_vld), .in_ready(),
      .out_data(up_data), .out_valid(up_vld), .out_ready(up_rdy),
      .level(up_lvl));

   // Infrared characters: status frames win over buffered data
   assign ctrl_pend = link_q && (!ok_q || stat_q != sent_q);
   assign irtx_vld  = link_q && (ctrl_pend || up_vld);
   assign irtx_data = ctrl_pend ? {1'b1, 5'h0, stat_q} : {1'b0, up_data};
   assign up_rdy    = link_q && !ctrl_pend && irtx_rdy;

   ispu_ser_tx #(.W(`ISPU_IR_W), .DIV(DIV)) u_irtx (
      .clk_sys(clk_sys), .rst(rst), .clr(clr),
      .in_data(irtx_data), .in_valid(irtx_vld), .in_ready(irtx_rdy),
      .ser_out(ir_serial_out));

   ispu_ser_rx #(.W(`ISPU_IR_W), .DIV(DIV)) u_irrx (
      .clk_sys(clk_sys), .rst(rst), .clr(clr),
      .ser_in(ir_serial_in),
      .out_data(irrx_data), .out_valid(irrx_vld));

   // Remote data goes to the host; remote status frames are dropped
   ispu_fifo #(.W(`ISPU_DATA_W), .DEPTH(DEPTH)) u_dn (
      .clk_sys(clk_sys), .rst(rst), .clr(clr),
      .in_data(irrx_data[7:0]),
      .in_valid(irrx_vld && !irrx_data[`ISPU_IR_TYPE_BIT]),
      .in_ready(dn_in_rdy),
      .out_data(dn_data), .out_valid(dn_vld), .out_ready(dn_rdy),
      .level());

   ispu_ser_tx #(.W(`ISPU_DATA_W), .DIV(DIV)) u_htx (
      .clk_sys(clk_sys), .rst(rst), .clr(clr),
      .in_data(dn_data),
      .in_valid(dn_vld && !hp.host_accept_n),
      .in_ready(htx_rdy),
      .ser_out(hp.host_serial_out));
   assign dn_rdy = htx_rdy && !hp.host_accept_n;

   // Link tracking, modem status sampling and local handshake
   always_comb begin
      stat_d = 3'h0;
      stat_d[`ISPU_CTRL_RING_BIT] = hp.bell_alert_in;
      stat_d[`ISPU_CTRL_DSR_BIT]  = hp.host_ready_n;
      stat_d[`ISPU_CTRL_CD_BIT]   = hp.carrier_sense_n;
      sent_d = sent_q;
      ok_d   = ok_q && link_q;
      if (ctrl_pend && irtx_rdy) begin
         sent_d = stat_q;
         ok_d   = 1'b1;
      end
      link_d = link_q;
      idle_d = idle_q + 32'h1;
      if (irrx_vld) begin       // Any remote frame, data or status, opens the link
         link_d = 1'b1;
         idle_d = 32'h0;
      end else if (!link_q || idle_q == 32'(LINK_IDLE - 1)) begin
         link_d = 1'b0;
         idle_d = 32'h0;
      end
      // Hold off while fewer than two slots remain free
      permit_n_d = clr || (up_lvl > LW'(DEPTH - 2));
      if (clr) begin
         link_d = 1'b0;
         ok_d   = 1'b0;
      end
   end

   // Status registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stat_q     <= 3'h7;
         sent_q     <= 3'h7;
         ok_q       <= 1'b0;
         link_q     <= 1'b0;
         idle_q     <= 32'h0;
         permit_n_q <= 1'b1;
      end else begin
         stat_q     <= stat_d;
         sent_q     <= sent_d;
         ok_q       <= ok_d;
         link_q     <= link_d;
         idle_q     <= idle_d;
         permit_n_q <= permit_n_d;
      end
   end

   assign hp.link_up_n     = !link_q;
   assign hp.send_permit_n = permit_n_q;
   assign link_active      = link_q;
endmodule

//--- verilog/ispu_host.sv
// Host end: controller UART and general pins facing the device
`timescale 1ns/1ps
`include "ispu_params.svh"

module ispu_host #(
   parameter int unsigned DIV = `ISPU_BAUD_DIV
) (
   input  wire logic         clk_sys,
   input  wire logic         rst,
   ispu_host_if.host         hp,
   input  ispu_pkg::ispu_byte_t tx_data,
   input  wire logic         tx_valid,
   output logic              tx_ready,
   output ispu_pkg::ispu_byte_t rx_data,
   output logic              rx_valid,
   input  wire logic         rx_ready,
   input  wire logic         ir_wanted,
   input  wire logic         ring_req,
   input  wire logic         carrier_req,
   input  wire logic         dev_reset_req,
   input  wire logic         dev_enable_req,
   output logic              link_seen
);
   import ispu_pkg::*;
   logic       tx_rdy_i;
   logic [5:0] pin_q, pin_d;

   // New characters start only while the device permits
   ispu_ser_tx #(.W(`ISPU_DATA_W), .DIV(DIV)) u_tx (
      .clk_sys(clk_sys), .rst(rst), .clr(1'b0),
      .in_data(tx_data),
      .in_valid(tx_valid && !hp.send_permit_n),
      .in_ready(tx_rdy_i),
      .ser_out(hp.host_serial_in));
   assign tx_ready = tx_rdy_i && !hp.send_permit_n;

   ispu_ser_rx #(.W(`ISPU_DATA_W), .DIV(DIV)) u_rx (
      .clk_sys(clk_sys), .rst(rst), .clr(1'b0),
      .ser_in(hp.host_serial_out),
      .out_data(rx_data), .out_valid(rx_valid));

   // Registered general pins, active low where the pin is
   always_comb begin
      pin_d[0] = !ir_wanted;
      pin_d[1] = !rx_ready;
      pin_d[2] = !ring_req;
      pin_d[3] = !carrier_req;
      pin_d[4] = dev_reset_req;
      pin_d[5] = dev_enable_req;
   end

   // Pin registers; device held in reset after host reset
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         pin_q <= 6'h1f;
      end else begin
         pin_q <= pin_d;
      end
   end

   assign hp.host_ready_n    = pin_q[0];
   assign hp.host_accept_n   = pin_q[1];
   assign hp.bell_alert_in   = pin_q[2];
   assign hp.carrier_sense_n = pin_q[3];
   assign hp.dev_reset       = pin_q[4];
   assign hp.dev_enable      = pin_q[5];
   assign link_seen          = !hp.link_up_n;
endmodule

//--- verilog/ispu_host_if.sv
// Pins between the host controller and the port device
`timescale 1ns/1ps
interface ispu_host_if;
   logic host_serial_in;
   logic host_serial_out;
   logic bell_alert_in;
   logic carrier_sense_n;
   logic link_up_n;
   logic host_ready_n;
   logic send_permit_n;
   logic host_accept_n;
   logic dev_reset;
   logic dev_enable;

   modport device (
      input  host_serial_in,
      output host_serial_out,
      input  bell_alert_in,
      input  carrier_sense_n,
      output link_up_n,
      input  host_ready_n,
      output send_permit_n,
      input  host_accept_n,
      input  dev_reset,
      input  dev_enable
   );

   modport host (
      output host_serial_in,
      input  host_serial_out,
      output bell_alert_in,
      output carrier_sense_n,
      input  link_up_n,
      output host_ready_n,
      input  send_permit_n,
      output host_accept_n,
      output dev_reset,
      output dev_enable
   );
endinterface

//--- verilog/ispu_params.svh
// Constants for the infrared stack host serial port
`ifndef ISPU_PARAMS_SVH
`define ISPU_PARAMS_SVH
`define ISPU_CLK_PERIOD_NS 10
`define ISPU_BAUD_DIV      868
`define ISPU_DATA_W        8
`define ISPU_IR_W          9
`define ISPU_FIFO_DEPTH    8
`define ISPU_LINK_IDLE_NS  2000000
`define ISPU_LINK_IDLE_CYC (`ISPU_LINK_IDLE_NS / `ISPU_CLK_PERIOD_NS)
`define ISPU_IR_TYPE_BIT   8
`define ISPU_CTRL_RING_BIT 2
`define ISPU_CTRL_DSR_BIT  1
`define ISPU_CTRL_CD_BIT   0
`define ISPU_LINE_IDLE     1'b1
`endif

//--- verilog/ispu_pkg.sv
// Types shared by both ends of the host serial port
package ispu_pkg;
   typedef logic [7:0] ispu_byte_t;
   typedef enum {SER_IDLE, SER_START, SER_DATA, SER_STOP} ispu_ser_e;
endpackage
